/* verilog/pfs_scan.sv */
// input filtering and sweep-ordered i/o scan engine
//
// How it works
// - writes analog-input, discrete-input, internal-bit memory; reads outputs; reads/writes global.
// - input points are sampled lowest address first, highest last.
// - output scan begins right after the logic solution completes.
// - outputs are updated in ascending address order, like inputs.
// - all outputs stay off from power-up until the first output scan ends.
// - filter time 0.5 to 20 ms in 0.5 ms steps, changeable live.
// - one setting unit equals half a millisecond, valid range 1 to 40.
// - settings below 1 act as 1, above 40 act as 40.
// - the filter setting word resets to 6, that is 3 ms.
// - effective filter time is within half a millisecond of the setting.
// - a pulse longer than sweep and filter time always reaches memory.
// - two pot channels, upper to first result word, lower to second.
// - one pot sample per sweep, average stored once the count is reached.
// - samples averaged equal two to the power of the exponent word.
// - only the low three exponent bits count, giving 0 to 7.
// - nothing published before the count; exponent zero publishes every sweep.
// - the exponent word resets to 4, sixteen samples.
// - diagnostics exist only as system status bits, none per point.
`include "pfs_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module pfs_scan #(
    parameter int TICK_CYCLES = `PFS_TICK_CYC
) (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire logic sweep_i,
    input wire logic logic_done_i,
    input wire logic [`PFS_N_DI-1:0] din_i,
    input wire logic [1:0][`PFS_WORD_W-1:0] pot_raw_i,
    input wire logic [`PFS_WORD_W-1:0] rd_data_i,
    output pfs_pkg::pfs_mem_rd_t rd_o,
    output pfs_pkg::pfs_mem_wr_t wr_o,
    output logic [`PFS_N_DQ-1:0] dout_o,
    output logic [1:0][`PFS_WORD_W-1:0] pot_result_o,
    output pfs_pkg::pfs_status_t status_o
);

    pfs_pkg::pfs_state_t state_q;
    logic [`PFS_IDX_W-1:0] idx_q;
    logic [`PFS_WORD_W-1:0] filt_set_q;
    logic [2:0] exp_q;
    logic [5:0] filt_lim;
    logic [13:0] tick_cnt_q;
    logic tick;
    logic [`PFS_N_DI-1:0] di_filt_q;
    logic [`PFS_N_DQ-1:0] dout_q;
    logic outs_on_q;
    logic [1:0] pot_have_q;
    pfs_pkg::pfs_mem_wr_t wr_q;

    // free-running half-millisecond tick
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            tick_cnt_q <= 14'h0000;
        else if (ce_i)
        begin
            if (tick)
                tick_cnt_q <= 14'h0000;
            else
                tick_cnt_q <= tick_cnt_q + 14'h0001;
        end
    end
    assign tick = (tick_cnt_q == 14'(TICK_CYCLES - 1));

    // setting word read as signed, clamped into the legal window
    always_comb
    begin
        if ($signed(filt_set_q) < $signed(`PFS_FILT_MIN))
            filt_lim = 6'(`PFS_FILT_MIN);
        else if ($signed(filt_set_q) > $signed(`PFS_FILT_MAX))
            filt_lim = 6'(`PFS_FILT_MAX);
        else
            filt_lim = filt_set_q[5:0];
    end

    // per-point stability filter; the tick is free running, so the first
    // interval is partial and the delay lands within one tick of the setting
    genvar gi;
    generate
        for (gi = 0; gi < `PFS_N_DI; gi++)
        begin : g_di
            logic [5:0] cnt_q;
            always_ff @(posedge mclk_i or negedge nrst_i)
            begin
                if (!nrst_i)
                begin
                    cnt_q <= 6'h00;
                    di_filt_q[gi] <= 1'b0;
                end
                else if (ce_i)
                begin
                    if (din_i[gi] == di_filt_q[gi])
                        cnt_q <= 6'h00;
                    else if (tick)
                    begin
                        if (cnt_q + 6'h01 >= filt_lim)
                        begin
                            di_filt_q[gi] <= din_i[gi];
                            cnt_q <= 6'h00;
                        end
                        else
                            cnt_q <= cnt_q + 6'h01;
                    end
                end
            end
        end
    endgenerate

    // pot averaging, one sample per sweep pulse
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_pot
            logic [`PFS_ACC_W-1:0] acc_q;
            logic [`PFS_ACC_W-1:0] sum;
            logic [7:0] n_q;
            logic [8:0] n_goal;
            logic [`PFS_ACC_W-1:0] avg;
            assign sum = acc_q + `PFS_ACC_W'(pot_raw_i[gi]);
            assign n_goal = 9'h001 << exp_q;
            assign avg = sum >> exp_q;
            always_ff @(posedge mclk_i or negedge nrst_i)
            begin
                if (!nrst_i)
                begin
                    acc_q <= '0;
                    n_q <= 8'h00;
                    pot_have_q[gi] <= 1'b0;
                    pot_result_o[gi] <= 16'h0000;
                end
                else if (ce_i && sweep_i && state_q == pfs_pkg::ST_IDLE)
                begin
                    if ({1'b0, n_q} + 9'h001 >= n_goal)
                    begin
                        pot_result_o[gi] <= avg[`PFS_WORD_W-1:0];
                        pot_have_q[gi] <= 1'b1;
                        acc_q <= '0;
                        n_q <= 8'h00;
                    end
                    else
                    begin
                        acc_q <= sum;
                        n_q <= n_q + 8'h01;
                    end
                end
            end
        end
    endgenerate

    // sweep sequencer: settings, inputs, pots, global, wait, outputs
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            state_q <= pfs_pkg::ST_IDLE;
            idx_q <= '0;
        end
        else if (ce_i)
        begin
            case (state_q)
                pfs_pkg::ST_IDLE:
                begin
                    idx_q <= '0;
                    if (sweep_i)
                        state_q <= pfs_pkg::ST_CFG;
                end
                pfs_pkg::ST_CFG:
                begin
                    idx_q <= idx_q + 5'h01;
                    if (idx_q == 5'h02)
                    begin
                        idx_q <= '0;
                        state_q <= pfs_pkg::ST_DI;
                    end
                end
                pfs_pkg::ST_DI:
                begin
                    idx_q <= idx_q + 5'h01;
                    if (idx_q == 5'(`PFS_N_DI - 1))
                    begin
                        idx_q <= '0;
                        state_q <= pfs_pkg::ST_POT;
                    end
                end
                pfs_pkg::ST_POT:
                begin
                    idx_q <= idx_q + 5'h01;
                    if (idx_q == 5'h01)
                    begin
                        idx_q <= '0;
                        state_q <= pfs_pkg::ST_GL;
                    end
                end
                pfs_pkg::ST_GL:
                begin
                    idx_q <= idx_q + 5'h01;
                    if (idx_q == 5'h01)
                    begin
                        idx_q <= '0;
                        state_q <= pfs_pkg::ST_WAIT;
                    end
                end
                pfs_pkg::ST_WAIT:
                    if (logic_done_i)
                        state_q <= pfs_pkg::ST_OUT;
                pfs_pkg::ST_OUT:
                begin
                    idx_q <= idx_q + 5'h01;
                    if (idx_q == 5'(`PFS_N_DQ))
                        state_q <= pfs_pkg::ST_DONE;
                end
                pfs_pkg::ST_DONE:
                begin
                    idx_q <= '0;
                    state_q <= pfs_pkg::ST_IDLE;
                end
                default:
                    state_q <= pfs_pkg::ST_IDLE;
            endcase
        end
    end

    // memory read requests, answered one cycle later on rd_data_i
    always_comb
    begin
        rd_o = '0;
        case (state_q)
            pfs_pkg::ST_CFG:
            begin
                rd_o.valid = (idx_q < 5'h02);
                rd_o.space = pfs_pkg::SP_AOUT;
                rd_o.addr = (idx_q == 5'h00) ? `PFS_AOUT_EXP_ADDR : `PFS_AOUT_FILT_ADDR;
            end
            pfs_pkg::ST_GL:
            begin
                rd_o.valid = (idx_q == 5'h00);
                rd_o.space = pfs_pkg::SP_GL;
                rd_o.addr = `PFS_G_SWEEP_ADDR;
            end
            pfs_pkg::ST_OUT:
            begin
                rd_o.valid = (idx_q < 5'(`PFS_N_DQ));
                rd_o.space = pfs_pkg::SP_DQ;
                rd_o.addr = 16'(idx_q);
            end
            default:
                rd_o = '0;
        endcase
    end

    // setting words, fetched from analog-output memory each sweep so a
    // change takes hold without a restart
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            filt_set_q <= `PFS_FILT_RST;
            exp_q <= `PFS_EXP_RST;
        end
        else if (ce_i && state_q == pfs_pkg::ST_CFG)
        begin
            if (idx_q == 5'h01)
                exp_q <= rd_data_i[2:0];
            if (idx_q == 5'h02)
                filt_set_q <= rd_data_i;
        end
    end

    // memory writes, registered
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            wr_q <= '0;
        else if (ce_i)
        begin
            wr_q <= '0;
            case (state_q)
                pfs_pkg::ST_DI:
                begin
                    wr_q.valid <= 1'b1;
                    wr_q.space <= pfs_pkg::SP_DI;
                    wr_q.addr <= 16'(idx_q);
                    wr_q.data <= {15'h0000, di_filt_q[idx_q[3:0]]};
                end
                pfs_pkg::ST_POT:
                begin
                    wr_q.valid <= pot_have_q[idx_q[0]];
                    wr_q.space <= pfs_pkg::SP_AIN;
                    wr_q.addr <= idx_q[0] ? `PFS_AIN_LOWER_ADDR : `PFS_AIN_UPPER_ADDR;
                    wr_q.data <= pot_result_o[idx_q[0]];
                end
                pfs_pkg::ST_GL:
                begin
                    wr_q.valid <= (idx_q == 5'h01);
                    wr_q.space <= pfs_pkg::SP_GL;
                    wr_q.addr <= `PFS_G_SWEEP_ADDR;
                    wr_q.data <= rd_data_i + 16'h0001;
                end
                pfs_pkg::ST_DONE:
                begin
                    wr_q.valid <= 1'b1;
                    wr_q.space <= pfs_pkg::SP_MI;
                    wr_q.addr <= `PFS_M_OUT_ON_ADDR;
                    wr_q.data <= 16'h0001;
                end
                default:
                    wr_q <= '0;
            endcase
        end
    end
    assign wr_o = wr_q;

    // output image, captured in ascending order as read data returns
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            dout_q <= '0;
        else if (ce_i && state_q == pfs_pkg::ST_OUT && idx_q != 5'h00)
            dout_q[4'(idx_q - 5'h01)] <= rd_data_i[0];
    end

    // outputs held off until the first full output scan has finished
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            outs_on_q <= 1'b0;
        else if (ce_i && state_q == pfs_pkg::ST_DONE)
            outs_on_q <= 1'b1;
    end
    assign dout_o = outs_on_q ? dout_q : '0;

    // only block-level status bits, no per-point diagnostics
    assign status_o.outputs_on = outs_on_q;
    assign status_o.scan_busy = (state_q != pfs_pkg::ST_IDLE);
    assign status_o.pot_ready = &pot_have_q;

endmodule : pfs_scan

`default_nettype wire

/* inc/pfs_consts.svh */
// constants for the input filter and i/o scan block
`ifndef PFS_CONSTS_SVH
`define PFS_CONSTS_SVH

// point counts and word widths
`define PFS_N_DI 16
`define PFS_N_DQ 16
`define PFS_WORD_W 16
`define PFS_ACC_W 23
`define PFS_IDX_W 5

// word addresses inside the data memories
`define PFS_AOUT_EXP_ADDR 16'h0001
`define PFS_AOUT_FILT_ADDR 16'h000b
`define PFS_AIN_UPPER_ADDR 16'h0010
`define PFS_AIN_LOWER_ADDR 16'h0011
`define PFS_G_SWEEP_ADDR 16'h0000
`define PFS_M_OUT_ON_ADDR 16'h0000

// reset values and limits of the setting words
`define PFS_FILT_RST 16'h0006
`define PFS_FILT_MIN 16'h0001
`define PFS_FILT_MAX 16'h0028
`define PFS_EXP_RST 3'h4

// half-millisecond filter tick
`define PFS_TICK_US 500
`define PFS_CLK_MHZ 20
`define PFS_TICK_CYC (`PFS_TICK_US * `PFS_CLK_MHZ)

`endif

/* inc/pfs_pkg.sv */
// types shared by the scan block and its bench
package pfs_pkg;

    // data memory spaces touched by the scanner
    typedef enum logic [2:0] {
        SP_AIN = 3'h0,
        SP_DI = 3'h1,
        SP_MI = 3'h2,
        SP_AOUT = 3'h3,
        SP_DQ = 3'h4,
        SP_GL = 3'h5
    } pfs_space_t;

    typedef struct packed {
        logic valid;
        pfs_space_t space;
        logic [15:0] addr;
        logic [15:0] data;
    } pfs_mem_wr_t;

    typedef struct packed {
        logic valid;
        pfs_space_t space;
        logic [15:0] addr;
    } pfs_mem_rd_t;

    // system status bits
    typedef struct packed {
        logic outputs_on;
        logic scan_busy;
        logic pot_ready;
    } pfs_status_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_CFG = 3'h1,
        ST_DI = 3'h2,
        ST_POT = 3'h3,
        ST_GL = 3'h4,
        ST_WAIT = 3'h5,
        ST_OUT = 3'h6,
        ST_DONE = 3'h7
    } pfs_state_t;

endpackage : pfs_pkg

/* sim/pfs_scan_monitor.sv */
// port-level assertions for the scan block
`timescale 1ns/1ps
`default_nettype none
`include "pfs_consts.svh"

module pfs_scan_monitor #(
    parameter int TICK_CYCLES = 10000
) (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire logic sweep_i,
    input wire logic logic_done_i,
    input wire logic [`PFS_N_DI-1:0] din_i,
    input wire logic [1:0][`PFS_WORD_W-1:0] pot_raw_i,
    input wire logic [`PFS_WORD_W-1:0] rd_data_i,
    input wire pfs_pkg::pfs_mem_rd_t rd_o,
    input wire pfs_pkg::pfs_mem_wr_t wr_o,
    input wire logic [`PFS_N_DQ-1:0] dout_o,
    input wire logic [1:0][`PFS_WORD_W-1:0] pot_result_o,
    input wire pfs_pkg::pfs_status_t status_o
);
    // one clock domain, so clock and reset are given once
    default clocking @(posedge mclk_i);
    endclocking
    default disable iff (!nrst_i);

    property p_out_off;
        !status_o.outputs_on |-> dout_o == '0;
    endproperty
    a_out_off: assert property (p_out_off)
        else $error("outputs driven before first output scan");

    property p_on_set;
        wr_o.valid && wr_o.space == pfs_pkg::SP_MI |-> ##[0:1] status_o.outputs_on;
    endproperty
    a_on_set: assert property (p_on_set)
        else $error("outputs not enabled after output scan");

    property p_wr_space;
        wr_o.valid |-> wr_o.space inside {pfs_pkg::SP_AIN, pfs_pkg::SP_DI, pfs_pkg::SP_MI,
            pfs_pkg::SP_GL};
    endproperty
    a_wr_space: assert property (p_wr_space)
        else $error("write into a read-only space");

    property p_rd_space;
        rd_o.valid |-> rd_o.space inside {pfs_pkg::SP_AOUT, pfs_pkg::SP_DQ, pfs_pkg::SP_GL};
    endproperty
    a_rd_space: assert property (p_rd_space)
        else $error("read from a space the scanner only writes");

    property p_di_order;
        wr_o.valid && wr_o.space == pfs_pkg::SP_DI && wr_o.addr != 16'h0000
            |-> $past(wr_o.valid) && $past(wr_o.addr) == wr_o.addr - 16'h0001;
    endproperty
    a_di_order: assert property (p_di_order)
        else $error("input words not written in ascending order");

    property p_dq_order;
        rd_o.valid && rd_o.space == pfs_pkg::SP_DQ && rd_o.addr != 16'h0000
            |-> $past(rd_o.valid) && $past(rd_o.addr) == rd_o.addr - 16'h0001;
    endproperty
    a_dq_order: assert property (p_dq_order)
        else $error("output words not read in ascending order");

    property p_dq_start;
        rd_o.valid && rd_o.space == pfs_pkg::SP_DQ && rd_o.addr == 16'h0000
            |-> $past(logic_done_i);
    endproperty
    a_dq_start: assert property (p_dq_start)
        else $error("output scan not started by logic completion");

    property p_pot_addr;
        wr_o.valid && wr_o.space == pfs_pkg::SP_AIN
            |-> wr_o.addr inside {`PFS_AIN_UPPER_ADDR, `PFS_AIN_LOWER_ADDR};
    endproperty
    a_pot_addr: assert property (p_pot_addr)
        else $error("pot result written to a wrong word");

    property p_di_bit;
        wr_o.valid && wr_o.space == pfs_pkg::SP_DI |-> wr_o.data[15:1] == 15'h0000;
    endproperty
    a_di_bit: assert property (p_di_bit)
        else $error("input word carries more than the point state");

    // busy status must cover every memory read of the sweep
    property p_rd_busy;
        rd_o.valid |-> status_o.scan_busy;
    endproperty
    a_rd_busy: assert property (p_rd_busy)
        else $error("memory read while status shows idle");
endmodule : pfs_scan_monitor

bind pfs_scan pfs_scan_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_mon (.mclk_i(mclk_i),
    .nrst_i(nrst_i), .ce_i(ce_i), .sweep_i(sweep_i), .logic_done_i(logic_done_i),
    .din_i(din_i), .pot_raw_i(pot_raw_i), .rd_data_i(rd_data_i), .rd_o(rd_o), .wr_o(wr_o),
    .dout_o(dout_o), .pot_result_o(pot_result_o), .status_o(status_o));
`default_nettype wire

/* sim/pfs_field_model.sv */
// behavioural data memory facing the scan block
`timescale 1ns/1ps
`default_nettype none
`include "pfs_consts.svh"

module pfs_field_model (
    input wire logic mclk_i,
    input wire pfs_pkg::pfs_mem_rd_t rd_i,
    input wire pfs_pkg::pfs_mem_wr_t wr_i,
    input wire logic [15:0] exp_word_i,
    input wire logic [15:0] filt_word_i,
    input wire logic [15:0] dq_word_i,
    output logic [15:0] rd_data_o
);
    logic [15:0] rd_q = 16'h5a5a;
    logic [15:0] gl_q = 16'h0000;

    // global word keeps whatever the scanner writes back
    always_ff @(posedge mclk_i)
    begin
        if (wr_i.valid && wr_i.space == pfs_pkg::SP_GL)
        begin
            gl_q <= wr_i.data;
        end
    end

    // answer the cycle after a request; idle bus toggles so stale data never matches
    always_ff @(posedge mclk_i)
    begin
        if (!rd_i.valid)
            rd_q <= ~rd_q;
        else if (rd_i.space == pfs_pkg::SP_DQ)
            rd_q <= {15'h0000, dq_word_i[rd_i.addr[3:0]]};
        else if (rd_i.space == pfs_pkg::SP_GL)
            rd_q <= gl_q;
        else
            rd_q <= (rd_i.addr == `PFS_AOUT_EXP_ADDR) ? exp_word_i : filt_word_i;
    end
    assign rd_data_o = rd_q;
endmodule : pfs_field_model
`default_nettype wire

/* sim/plc_input_filter_scan_tb.sv */
// self-checking bench for the filter and scan block
`timescale 1ns/1ps
`default_nettype none

module plc_input_filter_scan_tb;
    logic mclk_i = 0;
    logic nrst_i = 0;
    logic sweep_i = 0;
    logic logic_done_i = 0;
    logic [15:0] din_i = 16'h0000;
    logic [1:0][15:0] pot_raw_i = {16'h0123, 16'h0456};
    logic [15:0] rd_data_i;
    pfs_pkg::pfs_mem_rd_t rd_o;
    pfs_pkg::pfs_mem_wr_t wr_o;
    logic [15:0] dout_o;
    logic [1:0][15:0] pot_result_o;
    pfs_pkg::pfs_status_t status_o;
    logic [15:0] exp_w = 16'h0004;
    logic [15:0] filt_w = 16'h0028;
    logic [15:0] dq_w = 16'ha5c3;
    logic [15:0] di_seen = 16'h0000;
    logic [1:0][15:0] pot_seen = '0;
    logic [15:0] gl_seen = 16'h0000;
    int fail_count = 0;
    int samples_checked = 0;
    int cyc = 0;
    // filter cases: setting word, high time in clocks, expected point state
    logic [15:0] fs [6] = '{16'h0028, 16'h0028, 16'h0064, 16'h8000, 16'h000a, 16'h000a};
    int fh [6] = '{100, 170, 170, 10, 4, 50};
    logic fe [6] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};

    always #25 mclk_i = ~mclk_i;

    // short tick keeps filter runs brief
    pfs_scan #(.TICK_CYCLES(4)) dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .ce_i(1'b1),
        .sweep_i(sweep_i), .logic_done_i(logic_done_i), .din_i(din_i),
        .pot_raw_i(pot_raw_i), .rd_data_i(rd_data_i), .rd_o(rd_o), .wr_o(wr_o),
        .dout_o(dout_o), .pot_result_o(pot_result_o), .status_o(status_o));

    pfs_field_model u_field (.mclk_i(mclk_i), .rd_i(rd_o), .wr_i(wr_o), .exp_word_i(exp_w),
        .filt_word_i(filt_w), .dq_word_i(dq_w), .rd_data_o(rd_data_i));

    // record filtered input points as the scanner writes them
    always @(posedge mclk_i)
    begin
        if (wr_o.valid === 1'b1 && wr_o.space == pfs_pkg::SP_DI)
            di_seen[wr_o.addr[3:0]] = wr_o.data[0];
        if (wr_o.valid === 1'b1 && wr_o.space == pfs_pkg::SP_AIN)
            pot_seen[wr_o.addr[0]] = wr_o.data;
        if (wr_o.valid === 1'b1 && wr_o.space == pfs_pkg::SP_GL)
            gl_seen = wr_o.data;
    end

    // hang guard, far above the expected run length
    always @(posedge mclk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fail_count++;
            complete_run();
        end
    end

    task automatic check_w(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask : check_w

    // one full sweep: start, wait phase, logic done, output scan
    task automatic run_sweep();
        @(posedge mclk_i);
        #2 sweep_i = 1;
        @(posedge mclk_i);
        #2 sweep_i = 0;
        repeat (30) @(posedge mclk_i);
        #2 logic_done_i = 1;
        @(posedge mclk_i);
        #2 logic_done_i = 0;
        repeat (25) @(posedge mclk_i);
        #2;
    endtask : run_sweep

    task automatic t_reset();
        check_w("dout", 32'h0, {16'h0, dout_o});
        check_w("pot", 32'h0, pot_result_o);
        check_w("status", 32'h0, {29'h0, status_o});
    endtask : t_reset

    // inputs judged by the reset setting until the first fetch
    task automatic t_first_sweep();
        #2 din_i = 16'hffff;
        repeat (40) @(posedge mclk_i);
        run_sweep();
        check_w("din_image", 32'hffff, {16'h0, di_seen});
        check_w("dout", 32'ha5c3, {16'h0, dout_o});
        check_w("outputs_on", 32'h1, {31'h0, status_o.outputs_on});
        check_w("sweep_count", 32'h1, {16'h0, gl_seen});
    endtask : t_first_sweep

    task automatic t_avg_default();
        repeat (14) run_sweep();
        check_w("pot_15", 32'h0, pot_result_o);
        check_w("pot_word_15", 32'h0, pot_seen);
        run_sweep();
        check_w("pot_16", {16'h0123, 16'h0456}, pot_result_o);
        check_w("pot_word_16", {16'h0123, 16'h0456}, pot_seen);
        check_w("pot_ready", 32'h1, {31'h0, status_o.pot_ready});
    endtask : t_avg_default

    // exponent change lands one sweep late and the next sweep adds in the held sample, so allow two settling sweeps
    task automatic t_avg_exp();
        exp_w = 16'hfff8;
        repeat (3) run_sweep();
        check_w("pot_exp0", {16'h0123, 16'h0456}, pot_result_o);
        pot_raw_i = {16'h0777, 16'h0888};
        run_sweep();
        check_w("pot_every", {16'h0777, 16'h0888}, pot_result_o);
        exp_w = 16'h0009;
        run_sweep();
        pot_raw_i = {16'hfffe, 16'h0003};
        run_sweep();
        check_w("pot_hold", {16'h0777, 16'h0888}, pot_result_o);
        pot_raw_i = {16'hffff, 16'h0004};
        run_sweep();
        check_w("pot_avg2", {16'hfffe, 16'h0003}, pot_result_o);
    endtask : t_avg_exp

    task automatic t_filter();
        for (int i = 0; i < 6; i++)
        begin
            filt_w = fs[i];
            din_i = 16'h0000;
            run_sweep();
            repeat (200) @(posedge mclk_i);
            #2 din_i = 16'hffff;
            repeat (fh[i]) @(posedge mclk_i);
            run_sweep();
            check_w("din_filtered", {16'h0, {16{fe[i]}}}, {16'h0, di_seen});
        end
    endtask : t_filter

    task automatic t_outputs();
        dq_w = 16'h3c5a;
        run_sweep();
        check_w("dout", 32'h3c5a, {16'h0, dout_o});
        // thirty-six sweeps in all, each one read-modify-writes the global word
        check_w("sweep_count", 32'h24, {16'h0, gl_seen});
    endtask : t_outputs

    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : complete_run

    initial
    begin
        repeat (6) @(posedge mclk_i);
        #2 nrst_i = 1;
        t_reset();
        t_first_sweep();
        t_avg_default();
        t_avg_exp();
        t_filter();
        t_outputs();
        complete_run();
    end
endmodule : plc_input_filter_scan_tb
`default_nettype wire
